// ---- pkg/pcictl_pkg.sv ----
// Package for the bus control signalling block: timing counts and state codes.
// Assumes a single bus clock; all bus pins except idsel are active low at the pads.
package pcictl_pkg;
   localparam int CLK_MHZ = 40;
   localparam int CLK_PERIOD_NS = 25;
   // Parity error is reported this many clocks after detection
   localparam int PERR_DELAY_CLKS = 2;
   // Least time a sustained line is driven high before release
   localparam int PARK_CLKS = 1;
   // Least time the bus clock may be absent before clock run restarts it
   localparam int CLKRUN_HOLD_NS = 100;
   localparam int CLKRUN_HOLD_CLKS = (CLKRUN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] CMD_SPECIAL = 4'h1;
   localparam logic [3:0] CMD_CFG_RD = 4'hA;
   localparam logic [3:0] CMD_CFG_WR = 4'hB;

   typedef enum logic [4:0] {
      M_IDLE = 5'h01,
      M_ADDR = 5'h02,
      M_DATA = 5'h04,
      M_LAST = 5'h08,
      M_PARK = 5'h10
   } pcictl_mst_type;

   typedef enum logic [3:0] {
      T_IDLE = 4'h1,
      T_CLAIM = 4'h2,
      T_DATA = 4'h4,
      T_PARK = 4'h8
   } pcictl_tgt_type;
endpackage

// ---- hw/pcictl_top.sv ----
// Bus control signalling of a network controller acting as bus master and target.
// Assumes synchronous pin inputs, a bus clock of at least 16 MHz and address decode
// plus parity checking done by neighbouring logic.
// Overview of operation
// - As master, assert frame to start, hold it, release it in last data phase.
// - A data phase completes only when both ready lines are low together.
// - As target, assert stop to ask the master to end the transaction.
// - As master, watch stop and end the current transaction when it is seen.
// - Initialization select is the chip select for configuration reads and writes only.
// - As target, assert device select once own address is decoded.
// - As master, sample device select to learn whether the transfer was claimed.
// - Assert the own request line whenever bus ownership is needed.
// - Interrupt is open drain, active low, level, held while pending.
// - An address parity error drives system error low for exactly one clock.
// - Receiver asserts parity error two clocks after a data parity error.
// - Parity error lasts at least one clock per erroneous data phase.
// - Data parity errors are reported except in special cycles.
// - No parity error report before claiming and one completed data phase.
// - Clock run lets the system pause the clock; device refuses or restarts; here it drives clock run only while the line is low and keep_clock_in is set.
// - During bus reset, state returns to defaults and all bus outputs except power event float.
// - While isolated, drive nothing but power event and sample no bus inputs.
// - The isolate input also acts as a bus reset.
// - The power-up reset input resets the device.
// - Assert the open-drain power event line when a power event occurs.
// - Drive a sustained line high one clock before floating it.
module pcictl_top (
   // Clock and resets
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic bus_rst_b_in,
   input wire logic isolate_b_in,
   input wire logic power_up_reset_n_in,
   // Bus control pins, sampled
   input wire logic frame_b_in,
   input wire logic irdy_b_in,
   input wire logic trdy_b_in,
   input wire logic stop_b_in,
   input wire logic devsel_b_in,
   input wire logic idsel_in,
   input wire logic gnt_b_in,
   input wire logic clkrun_b_in,
   input wire logic [3:0] cmd_in,
   // Bus control pins, driven (enable low means driving)
   output logic frame_b_out,
   output logic frame_oe_b_out,
   output logic irdy_b_out,
   output logic irdy_oe_b_out,
   output logic trdy_b_out,
   output logic trdy_oe_b_out,
   output logic stop_b_out,
   output logic stop_oe_b_out,
   output logic devsel_b_out,
   output logic devsel_oe_b_out,
   output logic perr_b_out,
   output logic perr_oe_b_out,
   output logic req_b_out,
   output logic req_oe_b_out,
   output logic inta_oe_b_out,
   output logic serr_oe_b_out,
   output logic clkrun_oe_b_out,
   output logic pme_oe_b_out,
   // Core side
   input wire logic mst_start_in,
   input wire logic mst_last_in,
   input wire logic addr_hit_in,
   input wire logic tgt_ready_in,
   input wire logic tgt_stop_in,
   input wire logic addr_perr_in,
   input wire logic data_perr_in,
   input wire logic irq_pending_in,
   input wire logic pme_event_in,
   input wire logic keep_clock_in,
   output logic mst_done_out,
   output logic mst_abort_out,
   output logic mst_claimed_out,
   output logic cfg_sel_out,
   output logic phase_done_out
);
   import pcictl_pkg::*;

   typedef struct packed {
      pcictl_mst_type mst;
      pcictl_tgt_type tgt;
      logic [2:0] nack;
      logic req;
      logic claimed;
      logic cfg;
      logic phase_seen;
      logic special;
      logic perr_pipe;
      logic aperr_prev;
      logic perr_drv;
      logic perr_park;
      logic serr;
      logic inta;
      logic pme;
      logic clkrun;
      logic done;
      logic abort;
      logic pdone;
   } pcictl_state_type;

   pcictl_state_type s_q;
   pcictl_state_type s_d;
   logic run_rst_b;
   logic xfer;

   // Bus reset, isolate and power-up reset all clear the block except the power event line
   assign run_rst_b = rst_b_in & bus_rst_b_in & isolate_b_in & power_up_reset_n_in;
   assign xfer = !irdy_b_in && !trdy_b_in;

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.abort = 1'b0;
      s_d.pdone = xfer;
      // One pulse per rising run of the address parity error
      s_d.aperr_prev = addr_perr_in;
      s_d.serr = addr_perr_in && !s_q.aperr_prev;
      s_d.inta = irq_pending_in;
      s_d.pme = pme_event_in;
      s_d.clkrun = !clkrun_b_in && keep_clock_in;
      s_d.perr_pipe = 1'b0;
      s_d.perr_park = s_q.perr_drv && !s_q.perr_pipe;
      s_d.perr_drv = s_q.perr_pipe;
      case (s_q.mst)
         M_IDLE: begin
            if (mst_start_in) begin
               s_d.req = 1'b1;
            end
            if (s_q.req && !gnt_b_in && frame_b_in && irdy_b_in) begin
               s_d.mst = M_ADDR;
               s_d.req = 1'b0;
               s_d.nack = 3'h0;
            end
         end
         M_ADDR: begin
            s_d.mst = mst_last_in ? M_LAST : M_DATA;
         end
         M_DATA: begin
            s_d.nack = (devsel_b_in && s_q.nack != 3'h7) ? s_q.nack + 3'h1 : s_q.nack;
            if (!devsel_b_in) begin
               s_d.claimed = 1'b1;
            end
            if (!stop_b_in) begin
               s_d.mst = M_LAST;
               s_d.abort = 1'b1;
            end else if (mst_last_in) begin
               s_d.mst = M_LAST;
            end else if (s_q.nack == 3'h4) begin
               s_d.mst = M_LAST;
               s_d.abort = 1'b1;
            end
         end
         M_LAST: begin
            if (!devsel_b_in) begin
               s_d.claimed = 1'b1;
            end
            if (xfer || !stop_b_in || s_q.nack == 3'h5) begin
               s_d.mst = M_PARK;
               s_d.done = 1'b1;
               s_d.abort = s_q.abort || !stop_b_in || s_q.nack == 3'h5;
            end else begin
               s_d.nack = (devsel_b_in && s_q.nack != 3'h7) ? s_q.nack + 3'h1 : s_q.nack;
            end
         end
         M_PARK: begin
            s_d.mst = M_IDLE;
            s_d.claimed = 1'b0;
         end
         default: s_d.mst = M_IDLE;
      endcase
      case (s_q.tgt)
         T_IDLE: begin
            if (!frame_b_in && s_q.mst == M_IDLE) begin
               s_d.cfg = idsel_in && (cmd_in == CMD_CFG_RD || cmd_in == CMD_CFG_WR);
               s_d.special = (cmd_in == CMD_SPECIAL);
               s_d.phase_seen = 1'b0;
               if (addr_hit_in || s_d.cfg) begin
                  s_d.tgt = T_CLAIM;
               end
            end
         end
         T_CLAIM: begin
            s_d.tgt = T_DATA;
         end
         T_DATA: begin
            if (xfer) begin
               s_d.phase_seen = 1'b1;
               // Report error only for a claimed, completed, non-special phase
               if (data_perr_in && !s_q.special) begin
                  s_d.perr_pipe = 1'b1;
               end
               if (frame_b_in) begin
                  s_d.tgt = T_PARK;
               end
            end else if ((tgt_stop_in || !stop_b_out) && frame_b_in) begin
               s_d.tgt = T_PARK;
            end
         end
         T_PARK: begin
            s_d.tgt = T_IDLE;
            s_d.cfg = 1'b0;
         end
         default: s_d.tgt = T_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge run_rst_b) begin
      if (!run_rst_b) begin
         s_q <= '{mst: M_IDLE, tgt: T_IDLE, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge ref_clk_in or negedge run_rst_b) begin
      if (!run_rst_b) begin
         frame_b_out <= 1'b1;
         frame_oe_b_out <= 1'b1;
         irdy_b_out <= 1'b1;
         irdy_oe_b_out <= 1'b1;
         trdy_b_out <= 1'b1;
         trdy_oe_b_out <= 1'b1;
         stop_b_out <= 1'b1;
         stop_oe_b_out <= 1'b1;
         devsel_b_out <= 1'b1;
         devsel_oe_b_out <= 1'b1;
         perr_b_out <= 1'b1;
         perr_oe_b_out <= 1'b1;
         req_b_out <= 1'b1;
         req_oe_b_out <= 1'b1;
         inta_oe_b_out <= 1'b1;
         serr_oe_b_out <= 1'b1;
         clkrun_oe_b_out <= 1'b1;
         mst_done_out <= 1'b0;
         mst_abort_out <= 1'b0;
         mst_claimed_out <= 1'b0;
         cfg_sel_out <= 1'b0;
         phase_done_out <= 1'b0;
      end else begin
         frame_b_out <= !(s_d.mst == M_ADDR || s_d.mst == M_DATA);
         frame_oe_b_out <= !(s_d.mst inside {M_ADDR, M_DATA, M_LAST});
         irdy_b_out <= !(s_d.mst == M_DATA || s_d.mst == M_LAST);
         irdy_oe_b_out <= !(s_d.mst inside {M_ADDR, M_DATA, M_LAST, M_PARK});
         trdy_b_out <= !(s_d.tgt == T_DATA && tgt_ready_in);
         trdy_oe_b_out <= !(s_d.tgt inside {T_CLAIM, T_DATA, T_PARK});
         stop_b_out <= !(s_d.tgt == T_DATA && tgt_stop_in);
         stop_oe_b_out <= !(s_d.tgt inside {T_CLAIM, T_DATA, T_PARK});
         devsel_b_out <= !(s_d.tgt == T_CLAIM || s_d.tgt == T_DATA);
         devsel_oe_b_out <= !(s_d.tgt inside {T_CLAIM, T_DATA, T_PARK});
         perr_b_out <= !s_d.perr_drv;
         perr_oe_b_out <= !(s_d.perr_drv || s_d.perr_park);
         req_b_out <= !s_d.req;
         req_oe_b_out <= 1'b0;
         inta_oe_b_out <= !s_d.inta;
         serr_oe_b_out <= !s_d.serr;
         clkrun_oe_b_out <= !s_d.clkrun;
         mst_done_out <= s_d.done;
         mst_abort_out <= s_d.abort;
         mst_claimed_out <= s_d.claimed;
         cfg_sel_out <= s_d.cfg;
         phase_done_out <= s_d.pdone;
      end
   end

   // Power event line stays live while isolated; only the power-up reset clears it
   always_ff @(posedge ref_clk_in or negedge power_up_reset_n_in) begin
      if (!power_up_reset_n_in) begin
         pme_oe_b_out <= 1'b1;
      end else begin
         pme_oe_b_out <= !pme_event_in;
      end
   end

   a_serr_one_clk: assert property (@(posedge ref_clk_in) disable iff (!run_rst_b)
      !serr_oe_b_out |=> serr_oe_b_out) else $error("system error longer than one clock");

   a_perr_delay: assert property (@(posedge ref_clk_in) disable iff (!run_rst_b)
      (s_q.tgt == T_DATA && xfer && data_perr_in && !s_q.special) |-> ##2 !perr_b_out)
      else $error("parity error not two clocks after detection");

   a_perr_park: assert property (@(posedge ref_clk_in) disable iff (!run_rst_b)
      $rose(perr_oe_b_out) |-> $past(perr_b_out)) else $error("parity line floated low");

   a_special_quiet: assert property (@(posedge ref_clk_in) disable iff (!run_rst_b)
      (s_q.tgt == T_DATA && s_q.special) |-> ##2 perr_b_out)
      else $error("parity error in special cycle");

   a_frame_park: assert property (@(posedge ref_clk_in) disable iff (!run_rst_b)
      $rose(frame_oe_b_out) |-> $past(frame_b_out)) else $error("frame floated low");

   a_grant_first: assert property (@(posedge ref_clk_in) disable iff (!run_rst_b)
      (s_q.mst == M_IDLE && s_d.mst == M_ADDR) |-> !gnt_b_in)
      else $error("mastering without grant");

   sequence stop_seen_s;
      s_q.mst == M_DATA && !stop_b_in;
   endsequence
   a_stop_ends: assert property (@(posedge ref_clk_in) disable iff (!run_rst_b)
      stop_seen_s |=> frame_b_out ##1 frame_oe_b_out[*1] ##[0:6] irdy_oe_b_out)
      else $error("master ignored stop");

   a_devsel_claim: assert property (@(posedge ref_clk_in) disable iff (!run_rst_b)
      (s_q.tgt == T_CLAIM) |-> !devsel_b_out && !devsel_oe_b_out)
      else $error("claim without device select");

   a_irq_level: assert property (@(posedge ref_clk_in) disable iff (!run_rst_b)
      irq_pending_in |=> !inta_oe_b_out) else $error("interrupt not held");

   a_frame_last: assert property (@(posedge ref_clk_in) disable iff (!run_rst_b)
      (s_q.mst == M_LAST) |-> frame_b_out && !irdy_b_out)
      else $error("frame held in last phase");
endmodule

// ---- dv/pcictl_far.sv ----
// Far side model: bus arbiter plus a target that answers the device's own transactions.
// Assumes the bench resolves shared lines with pull-ups; devsel, trdy and stop outputs count only with drive_out.
module pcictl_far (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   // Bus lines seen
   input wire logic req_b_in,
   input wire logic frame_b_in,
   input wire logic irdy_b_in,
   // Behaviour chosen by the bench
   input wire logic claim_in,
   input wire logic stop_in,
   // Lines driven
   output logic gnt_b_out,
   output logic drive_out,
   output logic devsel_b_out,
   output logic trdy_b_out,
   output logic stop_b_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic act_q;
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         gnt_b_out <= 1'b1;
         act_q <= 1'b0;
         drive_out <= 1'b0;
         {devsel_b_out, trdy_b_out, stop_b_out} <= 3'h7;
      end else begin
         gnt_b_out <= req_b_in;
         if (!act_q && !frame_b_in) begin
            act_q <= 1'b1;
            drive_out <= 1'b1;
            devsel_b_out <= !claim_in;
            trdy_b_out <= !(claim_in && !stop_in);
            stop_b_out <= !(claim_in && stop_in);
         end else if (act_q && frame_b_in && irdy_b_in) begin
            // Park high for one clock before floating
            act_q <= 1'b0;
            {devsel_b_out, trdy_b_out, stop_b_out} <= 3'h7;
         end else if (!act_q) begin
            drive_out <= 1'b0;
         end
      end
   end
endmodule

// ---- dv/pcictl_top_tb.sv ----
// Bench for the bus control block; the bench acts as host master, pcictl_far as arbiter.
// Assumes pull-ups on all shared control lines and a 40 MHz bus clock.
module pcictl_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pcictl_pkg::*;
   logic ref_clk_in = 1'b0, rst_b_in = 1'b0, bus_rst_b_in = 1'b1, isolate_b_in = 1'b1;
   logic power_up_reset_n_in = 1'b1, h_frame = 1'b1, h_irdy = 1'b1, idsel_in = 1'b0;
   logic clkrun_b_in = 1'b1, claim = 1'b0, pstop = 1'b0, p_drv, p_dev, p_trdy, p_stop;
   logic [3:0] cmd_in = 4'h0;
   logic mst_start_in = 1'b0, mst_last_in = 1'b1, addr_hit_in = 1'b0, tgt_ready_in = 1'b1;
   logic tgt_stop_in = 1'b0, addr_perr_in = 1'b0, data_perr_in = 1'b0, irq_pending_in = 1'b0;
   logic pme_event_in = 1'b0, keep_clock_in = 1'b0, gnt_b_in;
   logic frame_b_out, frame_oe_b_out, irdy_b_out, irdy_oe_b_out, trdy_b_out, trdy_oe_b_out;
   logic stop_b_out, stop_oe_b_out, devsel_b_out, devsel_oe_b_out, perr_b_out, perr_oe_b_out;
   logic req_b_out, req_oe_b_out, inta_oe_b_out, serr_oe_b_out, clkrun_oe_b_out, pme_oe_b_out;
   logic mst_done_out, mst_abort_out, mst_claimed_out, cfg_sel_out, phase_done_out, ab_seen;
   logic cl_seen;
   wire frame_b_in = frame_oe_b_out ? h_frame : frame_b_out;
   wire irdy_b_in = irdy_oe_b_out ? h_irdy : irdy_b_out;
   wire trdy_b_in = !trdy_oe_b_out ? trdy_b_out : (p_drv ? p_trdy : 1'b1);
   wire stop_b_in = !stop_oe_b_out ? stop_b_out : (p_drv ? p_stop : 1'b1);
   wire devsel_b_in = !devsel_oe_b_out ? devsel_b_out : (p_drv ? p_dev : 1'b1);
   int fails = 0, checks = 0, cyc = 0, n_fr, n_req, n_dev, n_stop, n_perr, n_serr, n_done;
   int n_ph, n_cfg, xfer_at, perr_at;

   initial forever #12.5 ref_clk_in = ~ref_clk_in;

   pcictl_top i_pcictl_top (.ref_clk_in, .rst_b_in, .bus_rst_b_in, .isolate_b_in,
      .power_up_reset_n_in, .frame_b_in, .irdy_b_in, .trdy_b_in, .stop_b_in, .devsel_b_in,
      .idsel_in, .gnt_b_in, .clkrun_b_in, .cmd_in, .frame_b_out, .frame_oe_b_out, .irdy_b_out,
      .irdy_oe_b_out, .trdy_b_out, .trdy_oe_b_out, .stop_b_out, .stop_oe_b_out, .devsel_b_out,
      .devsel_oe_b_out, .perr_b_out, .perr_oe_b_out, .req_b_out, .req_oe_b_out,
      .inta_oe_b_out, .serr_oe_b_out, .clkrun_oe_b_out, .pme_oe_b_out, .mst_start_in,
      .mst_last_in, .addr_hit_in, .tgt_ready_in, .tgt_stop_in, .addr_perr_in, .data_perr_in,
      .irq_pending_in, .pme_event_in, .keep_clock_in, .mst_done_out, .mst_abort_out,
      .mst_claimed_out, .cfg_sel_out, .phase_done_out);

   pcictl_far i_pcictl_far (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
      .req_b_in(req_b_out), .frame_b_in(frame_oe_b_out | frame_b_out), .irdy_b_in(irdy_b_in),
      .claim_in(claim), .stop_in(pstop), .gnt_b_out(gnt_b_in), .drive_out(p_drv),
      .devsel_b_out(p_dev), .trdy_b_out(p_trdy), .stop_b_out(p_stop));

   // Event counters read by the scenarios
   always @(posedge ref_clk_in) begin
      cyc++;
      n_fr += (!frame_oe_b_out && !frame_b_out);
      n_req += !req_b_out;
      n_dev += (!devsel_oe_b_out && !devsel_b_out);
      n_stop += (!stop_oe_b_out && !stop_b_out);
      n_serr += !serr_oe_b_out;
      n_done += mst_done_out;
      n_ph += phase_done_out;
      n_cfg += cfg_sel_out;
      ab_seen |= mst_abort_out;
      cl_seen |= mst_claimed_out;
      if (!irdy_b_in && !trdy_b_in) xfer_at = cyc;
      if (!perr_oe_b_out && !perr_b_out && n_perr++ == 0) perr_at = cyc;
   end

   task automatic end_sim();
      if (fails == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %0h seen %0h", nm, exp, got);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask

   task automatic clr();
      @(negedge ref_clk_in);
      {n_fr, n_req, n_dev, n_stop, n_perr, n_serr, n_done, n_ph, n_cfg} = '0;
      {xfer_at, perr_at, ab_seen, cl_seen} = '0;
   endtask

   task automatic t_master(input logic cl, input logic ps, input logic ab);
      int i;
      clr();
      @(posedge ref_clk_in);
      claim <= cl;
      pstop <= ps;
      // Multi-phase burst unless a single claimed phase is wanted
      mst_last_in <= cl & !ps;
      mst_start_in <= 1'b1;
      @(posedge ref_clk_in);
      mst_start_in <= 1'b0;
      for (i = 0; i < 30 && n_done == 0; i++) step(1);
      if (n_done == 0) begin
         chk("done", 1, 0);
         end_sim();
      end
      step(3);
      @(negedge ref_clk_in);
      chk("req", 1, n_req != 0);
      chk("frame", 1, n_fr != 0);
      chk("frame_float", 1, frame_oe_b_out);
      chk("abort", ab, ab_seen);
      chk("claimed", cl, cl_seen);
      chk("phase", cl & !ps, n_ph != 0);
   endtask

   task automatic t_target(input logic [3:0] c, input logic id, input logic ts,
                           input logic dp, input logic ep, input logic ec);
      int i;
      clr();
      @(posedge ref_clk_in);
      {h_frame, cmd_in, idsel_in, addr_hit_in, tgt_stop_in} <= {1'b0, c, id, 1'b1, ts};
      @(posedge ref_clk_in);
      {h_frame, h_irdy, addr_hit_in, data_perr_in} <= {1'b1, 1'b0, 1'b0, dp};
      for (i = 0; i < 10 && trdy_b_in && stop_b_in; i++) @(posedge ref_clk_in);
      if (i == 10) begin
         chk("claim_wait", 0, 1);
         end_sim();
      end
      {h_irdy, data_perr_in} <= 2'h2;
      step(6);
      @(negedge ref_clk_in);
      chk("devsel", 1, n_dev != 0);
      chk("cfg_sel", ec, n_cfg != 0);
      chk("stop", ts, n_stop != 0);
      chk("perr", ep, n_perr != 0);
      if (ep) chk("perr_at", xfer_at + 2, perr_at);
   endtask

   task automatic t_side();
      clr();
      @(posedge ref_clk_in);
      addr_perr_in <= 1'b1;
      irq_pending_in <= 1'b1;
      {keep_clock_in, clkrun_b_in, pme_event_in} <= 3'h5;
      step(3);
      addr_perr_in <= 1'b0;
      step(3);
      @(negedge ref_clk_in);
      chk("serr", 1, n_serr);
      chk("inta", 0, inta_oe_b_out);
      chk("clkrun", 0, clkrun_oe_b_out);
      chk("pme", 0, pme_oe_b_out);
      @(posedge ref_clk_in);
      {bus_rst_b_in, keep_clock_in, irq_pending_in} <= 3'h0;
      step(2);
      @(negedge ref_clk_in);
      chk("bus_rst_oe", 3'h7, {inta_oe_b_out, clkrun_oe_b_out, frame_oe_b_out});
      @(posedge ref_clk_in);
      {bus_rst_b_in, isolate_b_in} <= 2'h2;
      step(2);
      @(negedge ref_clk_in);
      chk("iso_oe", 4'hF, {req_oe_b_out, serr_oe_b_out, perr_oe_b_out, devsel_oe_b_out});
      chk("iso_pme", 0, pme_oe_b_out);
      @(posedge ref_clk_in);
      isolate_b_in <= 1'b1;
      step(2);
      @(negedge ref_clk_in);
      chk("iso_req", 0, req_oe_b_out);
      @(posedge ref_clk_in);
      power_up_reset_n_in <= 1'b0;
      step(2);
      @(negedge ref_clk_in);
      chk("pur_pme", 1, pme_oe_b_out);
      @(posedge ref_clk_in);
      {pme_event_in, power_up_reset_n_in} <= 2'h1;
      step(2);
   endtask

   initial begin
      step(5);
      rst_b_in <= 1'b1;
      @(negedge ref_clk_in);
      chk("rst_oe", 10'h3FF, {frame_oe_b_out, irdy_oe_b_out, trdy_oe_b_out, stop_oe_b_out,
          devsel_oe_b_out, perr_oe_b_out, inta_oe_b_out, serr_oe_b_out, clkrun_oe_b_out,
          pme_oe_b_out});
      chk("rst_req", 1, req_oe_b_out);
      step(2);
      t_master(1'b1, 1'b0, 1'b0);
      t_master(1'b0, 1'b0, 1'b1);
      t_master(1'b1, 1'b1, 1'b1);
      t_target(CMD_CFG_RD, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
      t_target(CMD_CFG_WR, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      t_target(4'h6, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      t_target(4'h7, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      t_target(CMD_SPECIAL, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      t_side();
      end_sim();
   end
endmodule
